// ---- logic/rx_wakeup_sequencer.v ----
// Wake-up sequencer, carrier sense and modem readback with Wishbone registers
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "rx_wakeup_regs.vh"

module rx_wakeup_sequencer #(
    parameter MCLK_DIV_W = 16
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Wake-up pins
    input wire chip_sel_n_i,
    input wire serial_data_pin_i,
    // Receive chain
    input wire [5:0] rssi_avg_i,
    input wire rssi_valid_i,
    input wire [7:0] freq_offset_estimate_i,
    input wire [7:0] instant_freq_value_i,
    input wire cal_done_i,
    // Status pin and radio controls
    output reg status_pin_o,
    output reg rx_power_o,
    output reg cal_start_o,
    output reg gaussian_shaping_enable_o,
    output reg [7:0] tx_power_level_o,
    output reg demod_sample_tick_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n = rst_sync_reg;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] main_reg;
    reg [7:0] seq_reg;
    reg [4:0] cs_level_reg;
    reg [3:0] lock_sel_reg;
    reg [15:0] modem_div_reg;
    reg split_pins_reg;
    reg [7:0] fofs_reg;
    reg [7:0] ifreq_reg;
    reg carrier_sense_reg;
    reg ack_reg;

    wire [1:0] power_down_mode_field = main_reg[`MAIN_PDM_HI:`MAIN_PDM_LO];
    wire seq_mode = (power_down_mode_field == `PDM_SEQ);
    wire [1:0] sequencer_calibration_rate =
        main_reg[`MAIN_CAL_HI:`MAIN_CAL_LO];
    wire wake_trigger_source = seq_reg[`SEQ_SRC];
    wire [2:0] rx_wait = seq_reg[`SEQ_RXW_HI:`SEQ_RXW_LO];
    wire [3:0] cs_wait = seq_reg[`SEQ_CSW_HI:`SEQ_CSW_LO];

    wire req = wb_cyc_i & wb_stb_i;
    wire wr_en = req & wb_we_i & ~ack_reg & wb_sel_i[0];
    wire wr_hi = req & wb_we_i & ~ack_reg & wb_sel_i[1];
    assign wb_ack_o = ack_reg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_SLEEP = 5'b00010;
    localparam [4:0] ST_CAL = 5'b00100;
    localparam [4:0] ST_SETTLE = 5'b01000;
    localparam [4:0] ST_SENSE = 5'b10000;
    reg [4:0] state_reg;
    reg [4:0] state_next;

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            main_reg <= `RST_MAIN;
            seq_reg <= `RST_SEQ;
            cs_level_reg <= `RST_CSLVL;
            lock_sel_reg <= `RST_LOCKSEL;
            tx_power_level_o <= `RST_PWR;
            modem_div_reg <= `RST_MODEM;
            split_pins_reg <= `RST_IFACE;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (wr_en) begin
                case (wb_adr_i)
                    `ADR_MAIN: main_reg <= wb_dat_i[7:0];
                    `ADR_SEQ: seq_reg <= wb_dat_i[7:0];
                    `ADR_CSLVL: cs_level_reg <= wb_dat_i[4:0];
                    `ADR_LOCKSEL: lock_sel_reg <= wb_dat_i[3:0];
                    `ADR_PWR: tx_power_level_o <= wb_dat_i[7:0];
                    `ADR_MODEM: modem_div_reg[7:0] <= wb_dat_i[7:0];
                    `ADR_IFACE: split_pins_reg <= wb_dat_i[0];
                    default: ;
                endcase
            end
            if (wr_hi && wb_adr_i == `ADR_MODEM) begin
                modem_div_reg[15:8] <= wb_dat_i[15:8];
            end
            // Sleep bit self-clears once the sequencer has taken it
            if (seq_mode && state_reg == ST_IDLE && main_reg[`MAIN_SLEEP]
                && !(wr_en && wb_adr_i == `ADR_MAIN)) begin
                main_reg[`MAIN_SLEEP] <= 1'b0;
            end
        end
    end

    // Read multiplexer
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= 32'h00000000;
            if (req && !wb_we_i && !ack_reg) begin
                case (wb_adr_i)
                    `ADR_MAIN: wb_dat_o[7:0] <= main_reg;
                    `ADR_SEQ: wb_dat_o[7:0] <= seq_reg;
                    `ADR_CSLVL: wb_dat_o[4:0] <= cs_level_reg;
                    `ADR_LOCKSEL: wb_dat_o[3:0] <= lock_sel_reg;
                    `ADR_STATUS: begin
                        wb_dat_o[`ST_CS] <= carrier_sense_reg;
                        wb_dat_o[`ST_ASLEEP] <= (state_reg == ST_SLEEP);
                        wb_dat_o[`ST_BUSY] <=
                            (state_reg != ST_IDLE) && (state_reg != ST_SLEEP);
                        wb_dat_o[`ST_CAL] <= (state_reg == ST_CAL);
                    end
                    `ADR_FOFS: wb_dat_o[7:0] <= fofs_reg;
                    `ADR_IFREQ: wb_dat_o[7:0] <= ifreq_reg;
                    `ADR_PWR: wb_dat_o[7:0] <= tx_power_level_o;
                    `ADR_MODEM: wb_dat_o[15:0] <= modem_div_reg;
                    `ADR_IFACE: wb_dat_o[0] <= split_pins_reg;
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Modem clock divider: tick rate set as 8 x baud by software
    // ------------------------------------------------------------
    reg [MCLK_DIV_W-1:0] mclk_cnt_reg;
    reg mclk_level_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mclk_cnt_reg <= {MCLK_DIV_W{1'b0}};
            demod_sample_tick_o <= 1'b0;
            mclk_level_reg <= 1'b0;
        end else begin
            demod_sample_tick_o <= 1'b0;
            if (mclk_cnt_reg >= modem_div_reg[MCLK_DIV_W-1:0]) begin
                mclk_cnt_reg <= {MCLK_DIV_W{1'b0}};
                demod_sample_tick_o <= 1'b1;
                mclk_level_reg <= 1'b1;
            end else begin
                mclk_cnt_reg <= mclk_cnt_reg + 1'b1;
                if (mclk_cnt_reg ==
                    {1'b0, modem_div_reg[MCLK_DIV_W-1:1]}) begin
                    mclk_level_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Readback capture and carrier sense
    // ------------------------------------------------------------
    wire [5:0] cs_thresh = {1'b0, cs_level_reg} + `CS_MARGIN;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fofs_reg <= 8'h00;
            ifreq_reg <= 8'h00;
            carrier_sense_reg <= 1'b0;
        end else begin
            fofs_reg <= freq_offset_estimate_i;
            if (demod_sample_tick_o) begin
                ifreq_reg <= instant_freq_value_i;
            end
            if (rssi_valid_i) begin
                carrier_sense_reg <= (rssi_avg_i > cs_thresh);
            end
        end
    end

    // ------------------------------------------------------------
    // Status pin selection
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status_pin_o <= 1'b0;
            gaussian_shaping_enable_o <= 1'b0;
        end else begin
            gaussian_shaping_enable_o <= main_reg[`MAIN_SHAPE];
            case (lock_sel_reg)
                `LSEL_CS: status_pin_o <= carrier_sense_reg;
                `LSEL_MCLK: status_pin_o <= mclk_level_reg;
                default: status_pin_o <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Wake pin synchronisers and edge detect
    // ------------------------------------------------------------
    reg [1:0] csn_sync_reg;
    reg [1:0] dio_sync_reg;
    reg csn_prev_reg;
    reg dio_prev_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            csn_sync_reg <= 2'b11;
            dio_sync_reg <= 2'b11;
            csn_prev_reg <= 1'b1;
            dio_prev_reg <= 1'b1;
        end else begin
            csn_sync_reg <= {csn_sync_reg[0], chip_sel_n_i};
            dio_sync_reg <= {dio_sync_reg[0], serial_data_pin_i};
            csn_prev_reg <= csn_sync_reg[1];
            dio_prev_reg <= dio_sync_reg[1];
        end
    end

    wire csn_fall = csn_prev_reg & ~csn_sync_reg[1];
    wire dio_fall = dio_prev_reg & ~dio_sync_reg[1];
    wire wake = wake_trigger_source ? csn_fall
              : (split_pins_reg & dio_fall);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    reg [7:0] seq_cnt_reg;
    reg [11:0] wait_cnt_reg;
    reg [11:0] wait_cnt_next;
    reg [7:0] seq_cnt_next;
    reg cal_due;

    // Wait load: field x 256 sample ticks plus a fixed floor
    function [11:0] wait_load;
        input [3:0] units;
        begin
            wait_load = {units, 8'h00} + {4'h0, `WAIT_UNIT};
        end
    endfunction

    always @* begin
        case (sequencer_calibration_rate)
            `CAL_EVERY: cal_due = 1'b1;
            `CAL_16: cal_due = ((seq_cnt_reg & `CAL_MASK16) == 8'h00);
            `CAL_256: cal_due = (seq_cnt_reg == 8'h00);
            default: cal_due = 1'b0;
        endcase
    end

    always @* begin
        state_next = state_reg;
        wait_cnt_next = wait_cnt_reg;
        seq_cnt_next = seq_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (seq_mode && main_reg[`MAIN_SLEEP]) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!seq_mode) begin
                    state_next = ST_IDLE;
                end else if (wake) begin
                    seq_cnt_next = seq_cnt_reg + 8'h01;
                    wait_cnt_next = wait_load({1'b0, rx_wait});
                    state_next = cal_due ? ST_CAL : ST_SETTLE;
                end
            end
            ST_CAL: begin
                if (cal_done_i) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (demod_sample_tick_o) begin
                    if (wait_cnt_reg == 12'h000) begin
                        wait_cnt_next = wait_load(cs_wait);
                        state_next = ST_SENSE;
                    end else begin
                        wait_cnt_next = wait_cnt_reg - 12'h001;
                    end
                end
            end
            ST_SENSE: begin
                if (carrier_sense_reg) begin
                    state_next = ST_IDLE;
                end else if (demod_sample_tick_o) begin
                    if (wait_cnt_reg == 12'h000) begin
                        state_next = ST_SLEEP;
                    end else begin
                        wait_cnt_next = wait_cnt_reg - 12'h001;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            wait_cnt_reg <= 12'h000;
            seq_cnt_reg <= 8'hff;
            rx_power_o <= 1'b0;
            cal_start_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_cnt_reg <= wait_cnt_next;
            seq_cnt_reg <= seq_cnt_next;
            cal_start_o <= (state_next == ST_CAL) && (state_reg != ST_CAL);
            rx_power_o <= (state_next == ST_SETTLE) || (state_next == ST_SENSE)
                || (state_next == ST_IDLE && state_reg == ST_SENSE)
                || (rx_power_o && state_next == ST_IDLE);
        end
    end

endmodule // rx_wakeup_sequencer

// ---- logic/rx_wakeup_regs.vh ----
// Register offsets, field positions and reset values of the wake-up sequencer
`ifndef RX_WAKEUP_REGS_VH
`define RX_WAKEUP_REGS_VH

// Byte addresses
`define ADR_MAIN 8'h00
`define ADR_SEQ 8'h04
`define ADR_CSLVL 8'h08
`define ADR_LOCKSEL 8'h0c
`define ADR_STATUS 8'h10
`define ADR_FOFS 8'h14
`define ADR_IFREQ 8'h18
`define ADR_PWR 8'h1c
`define ADR_MODEM 8'h20
`define ADR_IFACE 8'h24

// Main register fields
`define MAIN_PDM_HI 1
`define MAIN_PDM_LO 0
`define MAIN_SLEEP 2
`define MAIN_CAL_HI 4
`define MAIN_CAL_LO 3
`define MAIN_SHAPE 5
`define PDM_SEQ 2'h3

// Sequencing register fields
`define SEQ_RXW_HI 2
`define SEQ_RXW_LO 0
`define SEQ_CSW_HI 6
`define SEQ_CSW_LO 3
`define SEQ_SRC 7

// Calibration rate codes
`define CAL_EVERY 2'h0
`define CAL_16 2'h1
`define CAL_256 2'h2
`define CAL_NEVER 2'h3
`define CAL_MASK16 8'h0f

// Status-pin selector codes
`define LSEL_CS 4'h4
`define LSEL_MCLK 4'hd

// Carrier sense margin above threshold
`define CS_MARGIN 6'h08

// Status register bits
`define ST_CS 3
`define ST_ASLEEP 0
`define ST_BUSY 1
`define ST_CAL 2

// Fixed floor added to every sequencer wait load, in sample ticks
`define WAIT_UNIT 8'h10

// Reset values
`define RST_MAIN 8'h00
`define RST_SEQ 8'h00
`define RST_CSLVL 5'h00
`define RST_LOCKSEL 4'h0
`define RST_PWR 8'h00
`define RST_MODEM 16'h0040
`define RST_IFACE 1'h0

`endif

// ---- testbench/rx_wakeup_sequencer_props.sv ----
// Port assertions for the wake-up sequencer
`timescale 1ns/1ps
`include "rx_wakeup_regs.vh"
module rx_wakeup_sequencer_props (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Radio controls
    input wire cal_start_o,
    input wire gaussian_shaping_enable_o,
    input wire [7:0] tx_power_level_o,
    input wire demod_sample_tick_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];

    AST_ACK_TAKEN: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_UNMAPPED: assert property (
        rd_ack && wb_adr_i > `ADR_IFACE |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_SHAPE: assert property (
        wr_ack && wb_adr_i == `ADR_MAIN |=> ##1
        gaussian_shaping_enable_o == $past(wb_dat_i[5], 2))
        else $error("shaping output wrong");
    AST_PWR_OUT: assert property (
        wr_ack && wb_adr_i == `ADR_PWR |=> ##1
        tx_power_level_o == $past(wb_dat_i[7:0], 2))
        else $error("power output wrong");
    AST_PWR_READ: assert property (
        rd_ack && wb_adr_i == `ADR_PWR |->
        wb_dat_o == {24'h0, tx_power_level_o})
        else $error("power readback wrong");
    AST_TICK: assert property (
        $rose(demod_sample_tick_o) |=> !demod_sample_tick_o)
        else $error("modem tick not a pulse");
    AST_CAL: assert property (
        cal_start_o |=> !cal_start_o)
        else $error("calibration start not a pulse");
endmodule // rx_wakeup_sequencer_props

bind rx_wakeup_sequencer rx_wakeup_sequencer_props u_props (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cal_start_o(cal_start_o),
    .gaussian_shaping_enable_o(gaussian_shaping_enable_o),
    .tx_power_level_o(tx_power_level_o),
    .demod_sample_tick_o(demod_sample_tick_o)
);

// ---- testbench/radio_chain_model.sv ----
// Receive-chain model: strength, offsets and calibration done
`timescale 1ns/1ps
module radio_chain_model #(
    parameter [7:0] OFFSET_VAL = 8'hf3
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Controls
    input wire [5:0] level_i,
    input wire demod_sample_tick_i,
    input wire cal_start_i,
    // Receive chain
    output reg [5:0] rssi_avg_o,
    output reg rssi_valid_o,
    output wire [7:0] freq_offset_estimate_o,
    output reg [7:0] instant_freq_value_o,
    output reg cal_done_o
);
    // ----------------------------------------
    // Behaviour
    // ----------------------------------------
    reg [1:0] div_reg;
    reg [2:0] cal_cnt_reg;
    assign freq_offset_estimate_o = OFFSET_VAL;
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 2'h0;
            cal_cnt_reg <= 3'h0;
            rssi_avg_o <= 6'h00;
            rssi_valid_o <= 1'b0;
            instant_freq_value_o <= 8'h00;
            cal_done_o <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            rssi_valid_o <= (div_reg == 2'h3);
            // Strength is only meaningful with valid
            rssi_avg_o <= (div_reg == 2'h3) ? level_i : ~level_i;
            if (demod_sample_tick_i)
                instant_freq_value_o <= instant_freq_value_o + 8'h0b;
            cal_done_o <= (cal_cnt_reg == 3'h1);
            if (cal_start_i)
                cal_cnt_reg <= 3'h4;
            else if (cal_cnt_reg != 3'h0)
                cal_cnt_reg <= cal_cnt_reg - 3'h1;
        end
    end
endmodule // radio_chain_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the wake-up sequencer
`timescale 1ns/1ps
`include "rx_wakeup_regs.vh"
module testbench;
    reg sys_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg wb_cyc = 1'b0;
    reg wb_stb = 1'b0;
    reg wb_we = 1'b0;
    reg [7:0] wb_adr = 8'h00;
    reg [31:0] wb_wdat = 32'h0;
    reg cs_n = 1'b1;
    reg sdata = 1'b1;
    reg [5:0] level = 6'h00;
    wire [31:0] wb_rdat;
    wire wb_ack, status_pin, rx_power, cal_start, shape, tick;
    wire rssi_valid, cal_done;
    wire [5:0] rssi;
    wire [7:0] fofs, ifreq, pwr;
    int errors = 0;
    int checks_done = 0;
    int cal_seen = 0;
    int n;
    int ones;
    logic [31:0] q;
    logic [31:0] q2;

    initial forever #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (cal_start === 1'b1) cal_seen++;

    rx_wakeup_sequencer u_rx_wakeup_sequencer (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hf),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .chip_sel_n_i(cs_n), .serial_data_pin_i(sdata), .rssi_avg_i(rssi),
        .rssi_valid_i(rssi_valid), .freq_offset_estimate_i(fofs),
        .instant_freq_value_i(ifreq), .cal_done_i(cal_done),
        .status_pin_o(status_pin), .rx_power_o(rx_power),
        .cal_start_o(cal_start), .gaussian_shaping_enable_o(shape),
        .tx_power_level_o(pwr), .demod_sample_tick_o(tick));
    radio_chain_model u_radio_chain_model (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .level_i(level), .demod_sample_tick_i(tick), .cal_start_i(cal_start),
        .rssi_avg_o(rssi), .rssi_valid_o(rssi_valid),
        .freq_offset_estimate_o(fofs),
        .instant_freq_value_o(ifreq), .cal_done_o(cal_done));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        check("bus ack", {31'h0, wb_ack}, 32'h1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task wait_rx(input logic v);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (rx_power !== v && n < 4000);
        check("rx power", {31'h0, rx_power}, {31'h0, v});
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        conclude;
    end

    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        bus(1'b0, `ADR_PWR, 32'h0);
        check("power reset", q, {24'h0, `RST_PWR});
        bus(1'b1, `ADR_PWR, 32'h5a);
        bus(1'b0, `ADR_PWR, 32'h0);
        check("power read", q, 32'h5a);
        check("power pins", {24'h0, pwr}, 32'h5a);
        bus(1'b1, `ADR_MAIN, 32'h20);
        @(posedge sys_clk_i);
        check("shaping", {31'h0, shape}, 32'h1);
        bus(1'b0, 8'h28, 32'h0);
        check("unmapped", q, 32'h0);
        bus(1'b0, `ADR_FOFS, 32'h0);
        check("offset", q, 32'hf3);
        // Carrier sense at the top threshold, at and above margin
        bus(1'b1, `ADR_CSLVL, 32'h1f);
        bus(1'b1, `ADR_LOCKSEL, {28'h0, `LSEL_CS});
        level <= 6'h27;
        repeat (12) @(posedge sys_clk_i);
        bus(1'b0, `ADR_STATUS, 32'h0);
        check("cs at margin", {31'h0, q[`ST_CS]}, 32'h0);
        check("cs pin low", {31'h0, status_pin}, 32'h0);
        level <= 6'h28;
        repeat (12) @(posedge sys_clk_i);
        bus(1'b0, `ADR_STATUS, 32'h0);
        check("cs above", {31'h0, q[`ST_CS]}, 32'h1);
        check("cs pin high", {31'h0, status_pin}, 32'h1);
        // Modem clock period and status pin
        bus(1'b1, `ADR_MODEM, 32'h7);
        bus(1'b1, `ADR_LOCKSEL, {28'h0, `LSEL_MCLK});
        repeat (2) @(posedge sys_clk_i);
        n = 0;
        do @(posedge sys_clk_i); while (tick !== 1'b1 && ++n < 100);
        n = 0;
        do @(posedge sys_clk_i); while (tick !== 1'b1 && ++n < 100);
        check("tick period", n + 1, 32'h8);
        ones = 0;
        repeat (8) @(posedge sys_clk_i) ones += (status_pin === 1'b1);
        check("mclk on pin", (ones > 0 && ones < 8), 32'h1);
        bus(1'b0, `ADR_IFREQ, 32'h0);
        q2 = q;
        repeat (20) @(posedge sys_clk_i);
        bus(1'b0, `ADR_IFREQ, 32'h0);
        check("ifreq moves", (q !== q2), 32'h1);
        // Sequencer woken by chip-select, no carrier, never calibrate
        level <= 6'h00;
        bus(1'b1, `ADR_SEQ, 32'h80);
        bus(1'b1, `ADR_MAIN, 32'h1f);
        bus(1'b0, `ADR_STATUS, 32'h0);
        check("asleep", {31'h0, q[`ST_ASLEEP]}, 32'h1);
        sdata <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        check("data pin ignored", {31'h0, rx_power}, 32'h0);
        sdata <= 1'b1;
        cs_n <= 1'b0;
        wait_rx(1'b1);
        cs_n <= 1'b1;
        wait_rx(1'b0);
        check("short waits", (n > 230 && n < 290), 32'h1);
        bus(1'b1, `ADR_SEQ, 32'h88);
        cs_n <= 1'b0;
        wait_rx(1'b1);
        cs_n <= 1'b1;
        wait_rx(1'b0);
        check("sense wait", (n > 2270 && n < 2340), 32'h1);
        check("no calibration", cal_seen, 32'h0);
        // Carrier present keeps the receiver up
        level <= 6'h30;
        cs_n <= 1'b0;
        wait_rx(1'b1);
        cs_n <= 1'b1;
        repeat (2600) @(posedge sys_clk_i);
        check("rx held", {31'h0, rx_power}, 32'h1);
        // Data-pin wake with calibration every time
        level <= 6'h00;
        bus(1'b1, `ADR_SEQ, 32'h00);
        bus(1'b1, `ADR_IFACE, 32'h1);
        bus(1'b1, `ADR_MAIN, 32'h07);
        sdata <= 1'b0;
        wait_rx(1'b1);
        repeat (20) @(posedge sys_clk_i);
        check("calibrated", cal_seen, 32'h1);
        sdata <= 1'b1;
        wait_rx(1'b0);
        // Sixteen wakes at the every-16th rate calibrate exactly once
        bus(1'b1, `ADR_MAIN, 32'h0b);
        repeat (16) begin
            sdata <= 1'b0;
            wait_rx(1'b1);
            sdata <= 1'b1;
            wait_rx(1'b0);
        end
        check("cal every 16th", cal_seen, 32'h2);
        conclude;
    end
endmodule // testbench
